// ==== rtp_pkg.sv ====
// constants, register map and carrier types for the rtd temperature protection block
package rtp_pkg;
	localparam int NUM_CH = 11;
	localparam int NUM_GRP = 4;
	localparam int NUM_VOTE = 2;
	localparam int TEMP_W = 16;
	localparam int CNT_W = 16;
	localparam int CHAN_W = 4;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int IRQ_W = 5;
	localparam int VOTE_CNT_W = 4;

	// register byte offsets
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] ADDR_CH_EN = 12'h004;
	localparam logic [ADDR_W-1:0] ADDR_ALM_EN = 12'h008;
	localparam logic [ADDR_W-1:0] ADDR_ALM_DLY = 12'h00c;
	localparam logic [ADDR_W-1:0] ADDR_TMO = 12'h010;
	localparam logic [ADDR_W-1:0] ADDR_VOTE1 = 12'h014;
	localparam logic [ADDR_W-1:0] ADDR_VOTE2 = 12'h018;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 12'h01c;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 12'h020;
	localparam logic [ADDR_W-1:0] ADDR_CH_STATE = 12'h024;
	localparam logic [ADDR_W-1:0] ADDR_GRP_STATE = 12'h028;
	localparam logic [ADDR_W-1:0] ADDR_CH_TMO = 12'h02c;
	localparam logic [ADDR_W-1:0] ADDR_CH_TRIP_BASE = 12'h040;
	localparam logic [ADDR_W-1:0] ADDR_CH_ALM_BASE = 12'h080;
	localparam logic [ADDR_W-1:0] ADDR_GRP_TRIP_BASE = 12'h0c0;
	localparam logic [ADDR_W-1:0] ADDR_GRP_ALM_BASE = 12'h0d0;
	localparam logic [ADDR_W-1:0] ADDR_TEMP_BASE = 12'h100;
	localparam int REGION_LSB = 6;
	localparam int GREGION_LSB = 4;
	localparam int IDX_LSB = 2;
	localparam int CH_IDX_W = 4;
	localparam int GRP_IDX_W = 2;

	// field positions
	localparam int CTRL_GLOBAL_EN_BIT = 0;
	localparam int CTRL_SRC_BIT = 1;
	localparam int CTRL_GRP_ALM_LSB = 4;
	localparam int VOTE_ACT_BIT = 0;
	localparam int VOTE_CNT_LSB = 4;
	localparam int VOTE_SEL_LSB = 16;
	localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0000_00f3;
	localparam logic [DATA_W-1:0] VOTE_MASK = 32'h07ff_00f1;
	localparam int IRQ_TRIP = 0;
	localparam int IRQ_ALARM = 1;
	localparam int IRQ_TMO = 2;
	localparam int IRQ_VOTE_LSB = 3;
	localparam int GST_ALM_LSB = 4;
	localparam int GST_TMO_LSB = 8;
	localparam int GST_VOTE_LSB = 12;
	localparam int GST_COLL_TRIP = 16;
	localparam int GST_COLL_ALM = 17;
	localparam int GST_COLL_TMO = 18;
	localparam int GST_MOD_TRIP = 19;
	localparam int CST_ALM_LSB = 16;

	// reset values
	localparam logic [TEMP_W-1:0] THR_RST = 16'h7fff;
	localparam logic [CNT_W-1:0] ALM_DLY_RST = 16'h000a;
	localparam logic [CNT_W-1:0] TMO_RST = 16'h03e8;

	// dropout ratio 0.99 as a fraction
	localparam int DROP_NUM = 99;
	localparam int DROP_DEN = 100;

	// timing: one protection tick per millisecond
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYC_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// group membership, group g occupies bits g*NUM_CH +: NUM_CH
	localparam logic [NUM_GRP*NUM_CH-1:0] GRP_MASKS = {11'h700, 11'h0c0, 11'h038, 11'h007};

	typedef struct packed {
		logic [CHAN_W-1:0] chan;
		logic [TEMP_W-1:0] value;
	} rtp_sample_t;

	typedef enum logic [2:0] {
		ALM_IDLE = 3'b001,
		ALM_TIMING = 3'b010,
		ALM_ON = 3'b100
	} rtp_alm_state_t;

	typedef enum logic [3:0] {
		REG_NONE, REG_CTRL, REG_CH_EN, REG_ALM_EN, REG_ALM_DLY, REG_TMO,
		REG_VOTE1, REG_VOTE2, REG_IRQ_STAT, REG_IRQ_MASK, REG_RO,
		REG_CH_TRIP, REG_CH_ALM, REG_GRP_TRIP, REG_GRP_ALM
	} rtp_reg_t;
endpackage

// ==== rtp_eval.sv ====
// one threshold evaluator: undelayed trip and delayed alarm with dropout hysteresis
`timescale 1ns/1ps
module rtp_eval #(
	parameter int TW = rtp_pkg::TEMP_W,
	parameter int CW = rtp_pkg::CNT_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic en,
	input wire logic alm_en,
	input wire logic tick,
	input wire logic [TW-1:0] temp,
	input wire logic [TW-1:0] trip_thr,
	input wire logic [TW-1:0] alm_thr,
	input wire logic [CW-1:0] alm_delay,
	output logic over_trip,
	output logic trip,
	output logic alarm
);
	import rtp_pkg::*;

	rtp_alm_state_t state_r;
	logic [CW-1:0] timer_r;
	logic trip_r;
	logic alm_act;
	logic [TW-1:0] trip_drop;
	logic [TW-1:0] alm_drop;

	// dropout level = thr * 0.99, rounded down
	function automatic logic [TW-1:0] drop_of(input logic [TW-1:0] thr);
		logic [TW+7:0] prod;
		prod = (TW+8)'(thr) * (TW+8)'(DROP_NUM);
		drop_of = TW'(prod / (TW+8)'(DROP_DEN));
	endfunction

	assign trip_drop = drop_of(trip_thr);
	assign alm_drop = drop_of(alm_thr);
	assign alm_act = en & alm_en;
	assign over_trip = en & (temp > trip_thr);
	assign trip = trip_r;
	assign alarm = (state_r == ALM_ON);

	// trip has only a threshold: no timer, no private enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trip_r <= 1'b0;
		end else if (!en) begin
			trip_r <= 1'b0;
		end else if (temp > trip_thr) begin
			trip_r <= 1'b1;
		end else if (temp < trip_drop) begin
			trip_r <= 1'b0;
		end
	end

	// alarm timer runs only while not below the dropout level, so a short excursion never alarms
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ALM_IDLE;
			timer_r <= '0;
		end else begin
			case (state_r)
				ALM_IDLE: begin
					timer_r <= '0;
					if (alm_act && temp > alm_thr) begin
						state_r <= ALM_TIMING;
					end
				end
				ALM_TIMING: begin
					if (!alm_act || temp < alm_drop) begin
						state_r <= ALM_IDLE;
					end else if (timer_r >= alm_delay) begin
						state_r <= ALM_ON;
					end else if (tick) begin
						timer_r <= timer_r + 1'b1;
					end
				end
				ALM_ON: begin
					if (!alm_act || temp < alm_drop) begin
						state_r <= ALM_IDLE;
					end
				end
				default: begin
					state_r <= ALM_IDLE;
				end
			endcase
		end
	end
endmodule

// ==== rtp_top.sv ====
// rtd temperature protection: channels, groups, voting, collectives and apb registers
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
module rtp_top #(
	parameter int TICK_CYC = rtp_pkg::TICK_CYC_DEF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rtp_pkg::ADDR_W-1:0] paddr,
	input wire logic [rtp_pkg::DATA_W-1:0] pwdata,
	output logic [rtp_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic temp_valid,
	input wire rtp_pkg::rtp_sample_t temp_sample,
	input wire logic block_trip_cmd,
	output logic [rtp_pkg::NUM_CH-1:0] ch_trip,
	output logic [rtp_pkg::NUM_CH-1:0] ch_alarm,
	output logic [rtp_pkg::NUM_CH-1:0] ch_timeout,
	output logic [rtp_pkg::NUM_GRP-1:0] grp_trip,
	output logic [rtp_pkg::NUM_GRP-1:0] grp_alarm,
	output logic [rtp_pkg::NUM_GRP-1:0] grp_timeout,
	output logic [rtp_pkg::NUM_VOTE-1:0] vote_trip,
	output logic all_groups_collective_trip,
	output logic all_groups_collective_alarm,
	output logic all_groups_collective_timeout,
	output logic module_trip,
	output logic irq
);
	import rtp_pkg::*;

	localparam int TICK_W = $clog2(TICK_CYC + 1);

	logic [DATA_W-1:0] ctrl_r;
	logic [NUM_CH-1:0] ch_en_r;
	logic [NUM_CH-1:0] alm_en_r;
	logic [CNT_W-1:0] alm_dly_r;
	logic [CNT_W-1:0] tmo_r;
	logic [DATA_W-1:0] vote_r [NUM_VOTE];
	logic [TEMP_W-1:0] ch_trip_thr_r [NUM_CH];
	logic [TEMP_W-1:0] ch_alm_thr_r [NUM_CH];
	logic [TEMP_W-1:0] grp_trip_thr_r [NUM_GRP];
	logic [TEMP_W-1:0] grp_alm_thr_r [NUM_GRP];
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic [TEMP_W-1:0] temp_r [NUM_CH];
	logic [CNT_W-1:0] tmo_cnt_r [NUM_CH];
	logic [TICK_W-1:0] tick_cnt_r;
	logic tick;
	logic pready_r;
	logic global_en;
	logic src_vote;
	logic [NUM_CH-1:0] ch_act;
	logic [NUM_CH-1:0] ch_over;
	logic [NUM_CH-1:0] ch_trip_raw;
	logic [NUM_CH-1:0] ch_alarm_raw;
	logic [NUM_CH-1:0] ch_tmo_raw;
	logic [NUM_GRP-1:0] grp_en;
	logic [NUM_GRP-1:0] grp_trip_raw;
	logic [NUM_GRP-1:0] grp_alarm_raw;
	logic [NUM_GRP-1:0] grp_tmo_nxt;
	logic [TEMP_W-1:0] grp_max [NUM_GRP];
	logic [VOTE_CNT_W-1:0] vote_cnt [NUM_VOTE];
	logic [NUM_VOTE-1:0] vote_nxt;
	logic [NUM_CH-1:0] ch_trip_nxt;
	logic [NUM_GRP-1:0] grp_trip_nxt;
	logic coll_trip_nxt;
	logic coll_alarm_nxt;
	logic coll_tmo_nxt;
	logic module_trip_nxt;
	logic [IRQ_W-1:0] irq_ev;
	rtp_reg_t reg_sel;
	logic [DATA_W-1:0] rdata_nxt;
	logic [CH_IDX_W-1:0] ch_idx;
	logic [GRP_IDX_W-1:0] grp_idx;
	logic acc_done;
	logic wr_en;

	assign global_en = ctrl_r[CTRL_GLOBAL_EN_BIT];
	assign src_vote = ctrl_r[CTRL_SRC_BIT];
	assign ch_act = {NUM_CH{global_en}} & ch_en_r;
	assign ch_idx = paddr[IDX_LSB +: CH_IDX_W];
	assign grp_idx = paddr[IDX_LSB +: GRP_IDX_W];
	assign acc_done = psel & penable & pready_r;
	assign wr_en = acc_done & pwrite;

	// millisecond tick for alarm delays and timeouts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_r <= '0;
			tick <= 1'b0;
		end else if (tick_cnt_r == TICK_W'(TICK_CYC - 1)) begin
			tick_cnt_r <= '0;
			tick <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
			tick <= 1'b0;
		end
	end

	// address decode and read mux; misaligned or unmapped gives pslverr
	always_comb begin
		reg_sel = REG_NONE;
		rdata_nxt = '0;
		if (paddr[IDX_LSB-1:0] != '0) begin
			reg_sel = REG_NONE;
		end else if (paddr == ADDR_CTRL) begin
			reg_sel = REG_CTRL;
			rdata_nxt = ctrl_r;
		end else if (paddr == ADDR_CH_EN) begin
			reg_sel = REG_CH_EN;
			rdata_nxt = DATA_W'(ch_en_r);
		end else if (paddr == ADDR_ALM_EN) begin
			reg_sel = REG_ALM_EN;
			rdata_nxt = DATA_W'(alm_en_r);
		end else if (paddr == ADDR_ALM_DLY) begin
			reg_sel = REG_ALM_DLY;
			rdata_nxt = DATA_W'(alm_dly_r);
		end else if (paddr == ADDR_TMO) begin
			reg_sel = REG_TMO;
			rdata_nxt = DATA_W'(tmo_r);
		end else if (paddr == ADDR_VOTE1) begin
			reg_sel = REG_VOTE1;
			rdata_nxt = vote_r[0];
		end else if (paddr == ADDR_VOTE2) begin
			reg_sel = REG_VOTE2;
			rdata_nxt = vote_r[1];
		end else if (paddr == ADDR_IRQ_STAT) begin
			reg_sel = REG_IRQ_STAT;
			rdata_nxt = DATA_W'(irq_stat_r);
		end else if (paddr == ADDR_IRQ_MASK) begin
			reg_sel = REG_IRQ_MASK;
			rdata_nxt = DATA_W'(irq_mask_r);
		end else if (paddr == ADDR_CH_STATE) begin
			reg_sel = REG_RO;
			rdata_nxt = DATA_W'(ch_trip);
			rdata_nxt[CST_ALM_LSB +: NUM_CH] = ch_alarm;
		end else if (paddr == ADDR_CH_TMO) begin
			reg_sel = REG_RO;
			rdata_nxt = DATA_W'(ch_timeout);
		end else if (paddr == ADDR_GRP_STATE) begin
			reg_sel = REG_RO;
			rdata_nxt = DATA_W'(grp_trip);
			rdata_nxt[GST_ALM_LSB +: NUM_GRP] = grp_alarm;
			rdata_nxt[GST_TMO_LSB +: NUM_GRP] = grp_timeout;
			rdata_nxt[GST_VOTE_LSB +: NUM_VOTE] = vote_trip;
			rdata_nxt[GST_COLL_TRIP] = all_groups_collective_trip;
			rdata_nxt[GST_COLL_ALM] = all_groups_collective_alarm;
			rdata_nxt[GST_COLL_TMO] = all_groups_collective_timeout;
			rdata_nxt[GST_MOD_TRIP] = module_trip;
		end else if (paddr[ADDR_W-1:REGION_LSB] == ADDR_CH_TRIP_BASE[ADDR_W-1:REGION_LSB]
			&& ch_idx < CH_IDX_W'(NUM_CH)) begin
			reg_sel = REG_CH_TRIP;
			rdata_nxt = DATA_W'(ch_trip_thr_r[ch_idx]);
		end else if (paddr[ADDR_W-1:REGION_LSB] == ADDR_CH_ALM_BASE[ADDR_W-1:REGION_LSB]
			&& ch_idx < CH_IDX_W'(NUM_CH)) begin
			reg_sel = REG_CH_ALM;
			rdata_nxt = DATA_W'(ch_alm_thr_r[ch_idx]);
		end else if (paddr[ADDR_W-1:REGION_LSB] == ADDR_TEMP_BASE[ADDR_W-1:REGION_LSB]
			&& ch_idx < CH_IDX_W'(NUM_CH)) begin
			reg_sel = REG_RO;
			rdata_nxt = DATA_W'(temp_r[ch_idx]);
		end else if (paddr[ADDR_W-1:GREGION_LSB] == ADDR_GRP_TRIP_BASE[ADDR_W-1:GREGION_LSB]) begin
			reg_sel = REG_GRP_TRIP;
			rdata_nxt = DATA_W'(grp_trip_thr_r[grp_idx]);
		end else if (paddr[ADDR_W-1:GREGION_LSB] == ADDR_GRP_ALM_BASE[ADDR_W-1:GREGION_LSB]) begin
			reg_sel = REG_GRP_ALM;
			rdata_nxt = DATA_W'(grp_alm_thr_r[grp_idx]);
		end
	end

	// one wait state: pready and read data both come from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready_r <= psel & penable & ~pready_r;
			if (psel && penable && !pready_r) begin
				prdata <= pwrite ? '0 : rdata_nxt;
				pslverr <= (reg_sel == REG_NONE);
			end else begin
				prdata <= '0;
				pslverr <= 1'b0;
			end
		end
	end
	assign pready = pready_r;

	// software settings; read-only and unmapped writes are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= '0;
			ch_en_r <= '0;
			alm_en_r <= '0;
			alm_dly_r <= ALM_DLY_RST;
			tmo_r <= TMO_RST;
			irq_mask_r <= '0;
			for (int v = 0; v < NUM_VOTE; v++) vote_r[v] <= '0;
			for (int c = 0; c < NUM_CH; c++) begin
				ch_trip_thr_r[c] <= THR_RST;
				ch_alm_thr_r[c] <= THR_RST;
			end
			for (int g = 0; g < NUM_GRP; g++) begin
				grp_trip_thr_r[g] <= THR_RST;
				grp_alm_thr_r[g] <= THR_RST;
			end
		end else if (wr_en) begin
			case (reg_sel)
				REG_CTRL: ctrl_r <= pwdata & CTRL_MASK;
				REG_CH_EN: ch_en_r <= pwdata[NUM_CH-1:0];
				REG_ALM_EN: alm_en_r <= pwdata[NUM_CH-1:0];
				REG_ALM_DLY: alm_dly_r <= pwdata[CNT_W-1:0];
				REG_TMO: tmo_r <= pwdata[CNT_W-1:0];
				REG_VOTE1: vote_r[0] <= pwdata & VOTE_MASK;
				REG_VOTE2: vote_r[1] <= pwdata & VOTE_MASK;
				REG_IRQ_MASK: irq_mask_r <= pwdata[IRQ_W-1:0];
				REG_CH_TRIP: ch_trip_thr_r[ch_idx] <= pwdata[TEMP_W-1:0];
				REG_CH_ALM: ch_alm_thr_r[ch_idx] <= pwdata[TEMP_W-1:0];
				REG_GRP_TRIP: grp_trip_thr_r[grp_idx] <= pwdata[TEMP_W-1:0];
				REG_GRP_ALM: grp_alm_thr_r[grp_idx] <= pwdata[TEMP_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// per channel: latest temperature, freshness timer, evaluator
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				temp_r[c] <= '0;
				tmo_cnt_r[c] <= '0;
			end else if (temp_valid && temp_sample.chan == CHAN_W'(c)) begin
				temp_r[c] <= temp_sample.value;
				tmo_cnt_r[c] <= '0;
			end else if (tick && tmo_cnt_r[c] != '1) begin
				tmo_cnt_r[c] <= tmo_cnt_r[c] + 1'b1;
			end
		end
		assign ch_tmo_raw[c] = ch_act[c] & (tmo_cnt_r[c] >= tmo_r);

		rtp_eval u_ch (
			.pclk(pclk),
			.presetn(presetn),
			.en(ch_act[c]),
			.alm_en(alm_en_r[c]),
			.tick(tick),
			.temp(temp_r[c]),
			.trip_thr(ch_trip_thr_r[c]),
			.alm_thr(ch_alm_thr_r[c]),
			.alm_delay(alm_dly_r),
			.over_trip(ch_over[c]),
			.trip(ch_trip_raw[c]),
			.alarm(ch_alarm_raw[c])
		);
	end

	// per group: hottest enabled member feeds the group evaluator
	for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
		always_comb begin
			grp_max[g] = '0;
			for (int c = 0; c < NUM_CH; c++) begin
				if (GRP_MASKS[g*NUM_CH+c] && ch_act[c] && temp_r[c] > grp_max[g]) begin
					grp_max[g] = temp_r[c];
				end
			end
		end
		assign grp_en[g] = |(ch_act & GRP_MASKS[g*NUM_CH +: NUM_CH]);
		assign grp_tmo_nxt[g] = |(ch_tmo_raw & GRP_MASKS[g*NUM_CH +: NUM_CH]);

		rtp_eval u_grp (
			.pclk(pclk),
			.presetn(presetn),
			.en(grp_en[g]),
			.alm_en(ctrl_r[CTRL_GRP_ALM_LSB+g]),
			.tick(tick),
			.temp(grp_max[g]),
			.trip_thr(grp_trip_thr_r[g]),
			.alm_thr(grp_alm_thr_r[g]),
			.alm_delay(alm_dly_r),
			.over_trip(),
			.trip(grp_trip_raw[g]),
			.alarm(grp_alarm_raw[g])
		);
	end

	// k-of-n voting over selected, enabled channels above their trip level
	for (genvar v = 0; v < NUM_VOTE; v++) begin : g_vote
		assign vote_cnt[v] = VOTE_CNT_W'($countones(ch_over & ch_act
			& vote_r[v][VOTE_SEL_LSB +: NUM_CH]));
		assign vote_nxt[v] = vote_r[v][VOTE_ACT_BIT]
			& (vote_r[v][VOTE_CNT_LSB +: VOTE_CNT_W] != '0)
			& (vote_cnt[v] >= vote_r[v][VOTE_CNT_LSB +: VOTE_CNT_W])
			& ~block_trip_cmd;
	end

	// trip suppression and collective terms
	// gate with the live enable so a channel switched off goes quiet at once
	assign ch_trip_nxt = ch_trip_raw & ch_act & {NUM_CH{~block_trip_cmd}};
	assign grp_trip_nxt = grp_trip_raw & {NUM_GRP{~block_trip_cmd}};
	assign coll_trip_nxt = (|ch_trip_nxt) | (|grp_trip_nxt);
	assign coll_alarm_nxt = (|(ch_alarm_raw & ch_act)) | (|grp_alarm_raw);
	assign coll_tmo_nxt = (|ch_tmo_raw) | (|grp_tmo_nxt);
	assign module_trip_nxt = src_vote ? (|vote_nxt) : (|ch_trip_nxt);
	assign irq_ev = {vote_nxt & ~vote_trip,
		coll_tmo_nxt & ~all_groups_collective_timeout,
		coll_alarm_nxt & ~all_groups_collective_alarm,
		coll_trip_nxt & ~all_groups_collective_trip};

	// all block outputs registered so downstream sees glitch-free levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch_trip <= '0;
			ch_alarm <= '0;
			ch_timeout <= '0;
			grp_trip <= '0;
			grp_alarm <= '0;
			grp_timeout <= '0;
			vote_trip <= '0;
			all_groups_collective_trip <= 1'b0;
			all_groups_collective_alarm <= 1'b0;
			all_groups_collective_timeout <= 1'b0;
			module_trip <= 1'b0;
		end else begin
			ch_trip <= ch_trip_nxt;
			ch_alarm <= ch_alarm_raw & ch_act;
			ch_timeout <= ch_tmo_raw;
			grp_trip <= grp_trip_nxt;
			grp_alarm <= grp_alarm_raw;
			grp_timeout <= grp_tmo_nxt;
			vote_trip <= vote_nxt;
			all_groups_collective_trip <= coll_trip_nxt;
			all_groups_collective_alarm <= coll_alarm_nxt;
			all_groups_collective_timeout <= coll_tmo_nxt;
			module_trip <= module_trip_nxt;
		end
	end

	// sticky status, write one to clear; a new event beats a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= '0;
			irq <= 1'b0;
		end else begin
			if (wr_en && reg_sel == REG_IRQ_STAT) begin
				irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_W-1:0]) | irq_ev;
			end else begin
				irq_stat_r <= irq_stat_r | irq_ev;
			end
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_ch0_hot;
		ch_act[0] && temp_r[0] > ch_trip_thr_r[0] && !block_trip_cmd;
	endsequence

	chk_block_trip: assert property (block_trip_cmd |=> ch_trip == '0 && grp_trip == '0)
		else $error("trip output seen while block-trip asserted");
	chk_chan_disable: assert property (1 |=> (ch_trip & ~$past(ch_act)) == '0)
		else $error("trip on a disabled channel");
	chk_alarm_enable: assert property (1 |=> ##1 (ch_alarm & ~$past(alm_en_r, 2)) == '0)
		else $error("alarm on a channel with alarm disabled");
	chk_trip_fast: assert property (s_ch0_hot [*3] |-> ch_trip[0])
		else $error("channel trip not asserted within two cycles");
	chk_vote_off: assert property (!vote_r[0][VOTE_ACT_BIT] |=> !vote_trip[0])
		else $error("inactive voting scheme tripped");
	chk_vote_count: assert property (vote_r[0][VOTE_ACT_BIT] && !block_trip_cmd
		&& vote_r[0][VOTE_CNT_LSB +: VOTE_CNT_W] != '0
		&& vote_cnt[0] >= vote_r[0][VOTE_CNT_LSB +: VOTE_CNT_W] |=> vote_trip[0])
		else $error("vote count reached but no voting trip");
	chk_trip_source: assert property (module_trip == ($past(src_vote) ? |vote_trip : |ch_trip))
		else $error("module trip does not follow source selection");
	chk_coll_trip: assert property (all_groups_collective_trip == (|ch_trip || |grp_trip))
		else $error("collective trip is not the OR of all trips");
	chk_coll_tmo: assert property (all_groups_collective_timeout == (|ch_timeout || |grp_timeout))
		else $error("collective timeout is not the OR of timeouts");
	chk_fresh_value: assert property (temp_valid && temp_sample.chan == '0 && tmo_r != '0
		|=> ##1 !ch_timeout[0])
		else $error("timeout despite a fresh value");
	chk_irq_level: assert property (irq == $past(|(irq_stat_r & irq_mask_r)))
		else $error("interrupt line does not follow masked status");
endmodule

// ==== rtp_remote_model.sv ====
// behavioural model of the remote temperature module feeding channel samples
`timescale 1ns/1ps
module rtp_remote_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic send_go,
	input wire logic [rtp_pkg::CHAN_W-1:0] send_chan,
	input wire logic [rtp_pkg::TEMP_W-1:0] send_value,
	output logic temp_valid,
	output rtp_pkg::rtp_sample_t temp_sample
);
	import rtp_pkg::*;
	// one strobe per fresh reading; between strobes the data toggles so stale use shows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			temp_valid <= 1'b0;
			temp_sample <= '0;
		end else begin
			temp_valid <= send_go;
			if (send_go) begin
				temp_sample <= {send_chan, send_value};
			end else begin
				temp_sample <= ~temp_sample;
			end
		end
	end
endmodule

// ==== tb_top.sv ====
// self-checking bench: apb setup, channel samples and output checks
`timescale 1ns/1ps
module tb_top;
	import rtp_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, temp_valid, irq;
	logic block_trip_cmd, module_trip, send_go, err;
	logic all_groups_collective_trip, all_groups_collective_alarm, all_groups_collective_timeout;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [CHAN_W-1:0] send_chan;
	logic [TEMP_W-1:0] send_value;
	rtp_sample_t temp_sample;
	logic [NUM_CH-1:0] ch_trip, ch_alarm, ch_timeout;
	logic [NUM_GRP-1:0] grp_trip, grp_alarm, grp_timeout;
	logic [NUM_VOTE-1:0] vote_trip;
	int failures, compares;
	// short tick keeps the delayed alarm and timeout tests brief
	rtp_top #(.TICK_CYC(10)) rtp_top_inst (.*);
	rtp_remote_model rtp_remote_model_inst (.*);
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	// one apb transfer; the request holds until pready is seen at an edge
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge pclk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		apb(0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic send(input logic [CHAN_W-1:0] c, input logic [TEMP_W-1:0] v);
		@(posedge pclk);
		send_go <= 1; send_chan <= c; send_value <= v;
		@(posedge pclk);
		send_go <= 0;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task finish_test;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// watchdog: the whole sequence needs well under 3000 cycles
	initial begin
		#300000;
		failures++;
		finish_test;
	end
	initial begin
		{psel, penable, pwrite, block_trip_cmd, send_go} = '0;
		paddr = '0; pwdata = '0; send_chan = '0; send_value = '0;
		failures = 0; compares = 0;
		presetn = 0;
		wt(2);
		presetn <= 1;
		rdchk(ADDR_CTRL, 32'h0);
		rdchk(ADDR_ALM_DLY, 32'h0000_000a);
		rdchk(ADDR_TMO, 32'h0000_03e8);
		rdchk(ADDR_CH_TRIP_BASE + 12'h028, 32'h0000_7fff);
		apb(0, 12'h200, 32'h0);
		chk({31'h0, err}, 32'h1);
		$display("test registers done");
		// hot sample while disabled must stay silent, then trip once enabled
		apb(1, ADDR_CH_TRIP_BASE, 32'h64);
		send(4'h0, 16'h00c8);
		wt(4);
		chk({21'h0, ch_trip}, 32'h0);
		apb(1, ADDR_TMO, 32'hffff);
		apb(1, ADDR_CH_EN, 32'h7ff);
		apb(1, ADDR_IRQ_MASK, 32'h1);
		apb(1, ADDR_CTRL, 32'h1);
		wt(4);
		chk({21'h0, ch_trip}, 32'h1);
		chk({30'h0, all_groups_collective_trip, module_trip}, 32'h3);
		chk({31'h0, irq}, 32'h1);
		apb(1, ADDR_IRQ_STAT, 32'h1);
		wt(2);
		chk({31'h0, irq}, 32'h0);
		send(4'h0, 16'h0063);
		wt(4);
		chk({21'h0, ch_trip}, 32'h1);
		send(4'h0, 16'h0062);
		wt(4);
		chk({21'h0, ch_trip}, 32'h0);
		send(4'h0, 16'h00c8);
		@(posedge pclk) block_trip_cmd <= 1;
		wt(4);
		chk({20'h0, module_trip, ch_trip}, 32'h0);
		@(posedge pclk) block_trip_cmd <= 0;
		apb(1, ADDR_GRP_TRIP_BASE, 32'h96);
		send(4'h1, 16'h0078);
		wt(4);
		chk({28'h0, grp_trip}, 32'h1);
		$display("test trip done");
		// delayed alarm on ch1 and group 0 only; ch2 crosses too but its alarm is disabled
		apb(1, ADDR_ALM_DLY, 32'h3);
		apb(1, ADDR_CH_ALM_BASE + 12'h004, 32'h32);
		apb(1, ADDR_CH_ALM_BASE + 12'h008, 32'h32);
		apb(1, ADDR_GRP_ALM_BASE, 32'h32);
		apb(1, ADDR_CTRL, 32'h11);
		apb(1, ADDR_ALM_EN, 32'h2);
		send(4'h1, 16'h003c);
		send(4'h2, 16'h003c);
		wt(12);
		chk({17'h0, grp_alarm, ch_alarm}, 32'h0);
		wt(30);
		chk({17'h0, grp_alarm, ch_alarm}, 32'h0000_0802);
		chk({31'h0, all_groups_collective_alarm}, 32'h1);
		$display("test alarm done");
		// vote 2 of ch3/ch4 routed to module trip; scheme 2 inactive
		send(4'h0, 16'h0032);
		apb(1, ADDR_CH_TRIP_BASE + 12'h00c, 32'h64);
		apb(1, ADDR_CH_TRIP_BASE + 12'h010, 32'h64);
		apb(1, ADDR_VOTE1, 32'h0018_0021);
		apb(1, ADDR_VOTE2, 32'h0018_0010);
		apb(1, ADDR_CTRL, 32'h3);
		send(4'h3, 16'h00c8);
		wt(4);
		chk({29'h0, module_trip, vote_trip}, 32'h0);
		send(4'h4, 16'h00c8);
		wt(4);
		chk({29'h0, module_trip, vote_trip}, 32'h5);
		apb(1, ADDR_CH_EN, 32'h7ef);
		wt(4);
		chk({30'h0, vote_trip}, 32'h0);
		$display("test voting done");
		// stale channels time out after three ticks without a fresh value
		apb(1, ADDR_TMO, 32'h3);
		wt(50);
		chk({21'h0, ch_timeout}, 32'h7ef);
		chk({27'h0, all_groups_collective_timeout, grp_timeout}, 32'h1f);
		$display("test timeout done");
		finish_test;
	end
endmodule
